// [verilog/rsx_pkg.sv]
// package for the rotate / subtract / swap / xor execution datapath
package rsx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;

  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROTATE_RIGHT_THRU_CARRY = 3'h1,
    OP_ROTATE_LEFT_THRU_CARRY = 3'h2,
    OP_SUB_ACCUM_FROM_REG = 3'h3,
    OP_NIBBLE_EXCHANGE = 3'h4,
    OP_XOR_IMMEDIATE_TO_ACCUM = 3'h5,
    OP_XOR_ACCUM_WITH_REG = 3'h6
  } rsx_op_t;

  // destination operand values
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // status bit positions
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_NIBBLE_SPILL = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_W = 3;

  // field positions and reset values
  localparam int unsigned MSB = DATA_W - 1;
  localparam int unsigned NIB_LO_HI = 3;
  localparam int unsigned NIB_HI_LO = 4;
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // one instruction as issued by the decoder
  typedef struct packed {
    rsx_op_t op;
    logic dest;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] reg_val;
    logic [DATA_W-1:0] literal;
  } rsx_instr_t;

  // result towards the register file
  typedef struct packed {
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rsx_wb_t;

endpackage

// [verilog/rsx_core.sv]
// combinational result and flag unit of the datapath
module rsx_core
  import rsx_pkg::*;
(
  input wire rsx_instr_t instr_i,
  input wire logic [DATA_W-1:0] accum_i,
  input wire logic [ST_W-1:0] status_i,
  output logic [DATA_W-1:0] result_o,
  output logic [ST_W-1:0] status_o,
  output logic writes_o
);

  logic [DATA_W:0] diff;
  logic [NIB_HI_LO:0] ndiff;
  logic carry_in;

  // borrow-free subtract: carry set means no borrow
  assign diff = {1'b0, instr_i.reg_val} + {1'b0, ~accum_i} + {{DATA_W{1'b0}}, 1'b1};
  assign ndiff = {1'b0, instr_i.reg_val[NIB_LO_HI:0]} + {1'b0, ~accum_i[NIB_LO_HI:0]}
    + {{NIB_HI_LO{1'b0}}, 1'b1};
  assign carry_in = status_i[ST_CARRY];

  // one result per operation, untouched flags pass through
  always_comb begin
    result_o = DATA_ZERO;
    status_o = status_i;
    writes_o = 1'b1;
    case (instr_i.op)
      OP_ROTATE_RIGHT_THRU_CARRY: begin
        result_o = {carry_in, instr_i.reg_val[MSB:1]};
        status_o[ST_CARRY] = instr_i.reg_val[0];
      end
      OP_ROTATE_LEFT_THRU_CARRY: begin
        result_o = {instr_i.reg_val[MSB-1:0], carry_in};
        status_o[ST_CARRY] = instr_i.reg_val[MSB];
      end
      OP_SUB_ACCUM_FROM_REG: begin
        result_o = diff[DATA_W-1:0];
        status_o[ST_CARRY] = diff[DATA_W];
        status_o[ST_NIBBLE_SPILL] = ndiff[NIB_HI_LO];
        status_o[ST_ZERO] = (diff[DATA_W-1:0] == DATA_ZERO);
      end
      OP_NIBBLE_EXCHANGE: begin
        result_o = {instr_i.reg_val[NIB_LO_HI:0], instr_i.reg_val[MSB:NIB_HI_LO]};
      end
      OP_XOR_IMMEDIATE_TO_ACCUM: begin
        result_o = accum_i ^ instr_i.literal;
        status_o[ST_ZERO] = ((accum_i ^ instr_i.literal) == DATA_ZERO);
      end
      OP_XOR_ACCUM_WITH_REG: begin
        result_o = accum_i ^ instr_i.reg_val;
        status_o[ST_ZERO] = ((accum_i ^ instr_i.reg_val) == DATA_ZERO);
      end
      default: begin
        writes_o = 1'b0;
      end
    endcase
  end

endmodule

// [verilog/rsx_alu.sv]
// execution datapath for rotate, subtract, swap and xor instructions
module rsx_alu
  import rsx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic issue_i,
  input wire rsx_instr_t instr_i,
  output logic [DATA_W-1:0] accum_o,
  output logic [ST_W-1:0] status_o,
  output rsx_wb_t wb_o,
  output logic done_o
);

  logic [DATA_W-1:0] accum_ff;
  logic [ST_W-1:0] status_ff;
  rsx_wb_t wb_ff;
  logic done_ff;
  logic [DATA_W-1:0] nxt_result;
  logic [ST_W-1:0] nxt_status;
  logic writes;
  logic to_reg;

  rsx_core u_core (
    .instr_i(instr_i),
    .accum_i(accum_ff),
    .status_i(status_ff),
    .result_o(nxt_result),
    .status_o(nxt_status),
    .writes_o(writes)
  );

  // immediate xor always lands in the accumulator whatever the dest bit says
  assign to_reg = (instr_i.dest == DEST_REG) && (instr_i.op != OP_XOR_IMMEDIATE_TO_ACCUM);

  // accumulator update
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accum_ff <= ACCUM_RST;
    end else if (issue_i && writes && !to_reg) begin
      accum_ff <= nxt_result;
    end
  end

  // status update; bits an op does not touch come back unchanged from the core
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= STATUS_RST;
    end else if (issue_i && writes) begin
      status_ff <= nxt_status;
    end
  end

  // register file write-back, one cycle pulse with registered data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ff <= '0;
    end else begin
      wb_ff.wr_en <= issue_i && writes && to_reg;
      if (issue_i && writes) begin
        wb_ff.addr <= instr_i.addr;
        wb_ff.data <= nxt_result;
      end
    end
  end

  // completion pulse for every accepted operation
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= issue_i && writes;
    end
  end

  assign accum_o = accum_ff;
  assign status_o = status_ff;
  assign wb_o = wb_ff;
  assign done_o = done_ff;

  // checks
  AST_RR_CARRY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_ROTATE_RIGHT_THRU_CARRY |=>
    status_ff[ST_CARRY] == $past(instr_i.reg_val[0])) else $error("rotate right carry");
  AST_RR_DATA: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_ROTATE_RIGHT_THRU_CARRY && !to_reg |=>
    accum_ff == {$past(status_ff[ST_CARRY]), $past(instr_i.reg_val[MSB:1])})
    else $error("rotate right data");
  AST_DEST_REG: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && writes && to_reg |=> wb_ff.wr_en && $stable(accum_ff))
    else $error("register destination");
  AST_DEST_ACC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && writes && !to_reg |=> !wb_ff.wr_en && accum_ff == wb_ff.data)
    else $error("accumulator destination");
  AST_SUB: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_SUB_ACCUM_FROM_REG |=>
    wb_ff.data == 8'($past(instr_i.reg_val) - $past(accum_ff)) &&
    status_ff[ST_CARRY] == ($past(instr_i.reg_val) >= $past(accum_ff)))
    else $error("subtract");
  AST_SWAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_NIBBLE_EXCHANGE |=>
    wb_ff.data == {$past(instr_i.reg_val[3:0]), $past(instr_i.reg_val[7:4])} &&
    $stable(status_ff)) else $error("swap");
  AST_XORL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_XOR_IMMEDIATE_TO_ACCUM |=>
    accum_ff == ($past(accum_ff) ^ $past(instr_i.literal)) && !wb_ff.wr_en &&
    status_ff[1:0] == $past(status_ff[1:0])) else $error("xor immediate");
  AST_XORF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_XOR_ACCUM_WITH_REG |=>
    wb_ff.data == ($past(accum_ff) ^ $past(instr_i.reg_val)) &&
    status_ff[1:0] == $past(status_ff[1:0])) else $error("xor register");
  AST_RL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_ROTATE_LEFT_THRU_CARRY |=>
    wb_ff.data == {$past(instr_i.reg_val[6:0]), $past(status_ff[ST_CARRY])})
    else $error("rotate left");
  AST_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && (instr_i.op == OP_SUB_ACCUM_FROM_REG || instr_i.op == OP_XOR_ACCUM_WITH_REG) |=>
    status_ff[ST_ZERO] == (wb_ff.data == DATA_ZERO)) else $error("zero flag");

  COV_RR_REG: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_ROTATE_RIGHT_THRU_CARRY && to_reg);
  COV_SUB_BORROW: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_SUB_ACCUM_FROM_REG ##1 !status_ff[ST_CARRY]);
  COV_XOR_ZERO: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && instr_i.op == OP_XOR_IMMEDIATE_TO_ACCUM ##1 status_ff[ST_ZERO]);
  COV_B2B: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    issue_i && writes ##1 issue_i && writes);

endmodule

// [verification/rsx_regfile_model.sv]
// register file model standing in for the core's data memory
module rsx_regfile_model
  import rsx_pkg::*;
(
  input wire logic clock_i,
  input wire logic issue_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire rsx_wb_t wb_i,
  output logic [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem_ff [2**ADDR_W];
  // known start pattern, mirrored by the bench
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem_ff[i] = DATA_W'(i * 37 + 1);
    end
  end
  // write back lands one edge after the result, before the next issue
  always @(posedge clock_i) begin
    if (wb_i.wr_en === 1'b1) begin
      mem_ff[wb_i.addr] <= wb_i.data;
    end
  end
  // outside an issue the read port shows the inverse, never a held value
  assign rd_data_o = issue_i ? mem_ff[addr_i] : ~mem_ff[addr_i];
endmodule

// [verification/rsx_alu_tb.sv]
// self-checking bench for the rotate / subtract / swap / xor datapath
module rsx_alu_tb
  import rsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    rsx_op_t op;
    logic [DATA_W-1:0] acc;
    logic [ST_W-1:0] st;
    logic we;
    logic [ADDR_W-1:0] ad;
    logic [DATA_W-1:0] d;
  } rsx_exp_t;
  logic clock, rst_n, issue, done;
  rsx_instr_t req, instr;
  logic [DATA_W-1:0] accum, rd, acc;
  logic [ST_W-1:0] status, st;
  rsx_wb_t wb;
  logic [DATA_W-1:0] mirror [2**ADDR_W];
  logic [31:0] lfsr = 32'hb5d2_1bf6;
  rsx_exp_t exp_q [$];
  rsx_exp_t got;
  int fails = 0;
  int num_checks = 0;
  rsx_alu i_rsx_alu (.clock_i(clock), .rst_n_i(rst_n), .issue_i(issue), .instr_i(instr),
    .accum_o(accum), .status_o(status), .wb_o(wb), .done_o(done));
  rsx_regfile_model i_rsx_regfile_model (.clock_i(clock), .issue_i(issue), .addr_i(req.addr),
    .wb_i(wb), .rd_data_o(rd));
  // operand comes from the register file, the rest from the bench
  always_comb begin
    instr = req;
    instr.reg_val = rd;
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reference behaviour worked out from the mirrored accumulator and status
  function automatic rsx_exp_t ref_op(rsx_op_t op, logic dd, logic [ADDR_W-1:0] ad,
      logic [DATA_W-1:0] r, logic [DATA_W-1:0] l);
    rsx_exp_t e;
    e = '{op: op, acc: acc, st: st, we: dd, ad: ad, d: 8'h00};
    case (op)
      OP_ROTATE_RIGHT_THRU_CARRY: e = '{op, acc, {st[2:1], r[0]}, dd, ad, {st[0], r[7:1]}};
      OP_ROTATE_LEFT_THRU_CARRY: e = '{op, acc, {st[2:1], r[7]}, dd, ad, {r[6:0], st[0]}};
      OP_SUB_ACCUM_FROM_REG: e = '{op, acc, {1'b0, r[3:0] >= acc[3:0], r >= acc}, dd, ad, r - acc};
      OP_NIBBLE_EXCHANGE: e.d = {r[3:0], r[7:4]};
      OP_XOR_IMMEDIATE_TO_ACCUM: e = '{op, acc, st, 1'b0, ad, acc ^ l};
      default: e.d = acc ^ r;
    endcase
    if (op inside {OP_SUB_ACCUM_FROM_REG, OP_XOR_IMMEDIATE_TO_ACCUM, OP_XOR_ACCUM_WITH_REG}) begin
      e.st[ST_ZERO] = (e.d == DATA_ZERO);
    end
    if (!e.we) begin
      e.acc = e.d;
    end
    return e;
  endfunction
  // one issue cycle, then one idle so the write back lands first
  task automatic op_do(rsx_op_t op, logic dd, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] l);
    rsx_exp_t e;
    e = ref_op(op, dd, ad, mirror[ad], l);
    @(posedge clock);
    issue <= 1'b1;
    req <= '{op: op, dest: dd, addr: ad, reg_val: 8'h00, literal: l};
    @(posedge clock);
    issue <= 1'b0;
    if (op inside {[OP_ROTATE_RIGHT_THRU_CARRY:OP_XOR_ACCUM_WITH_REG]}) begin
      exp_q.push_back(e);
      acc = e.acc;
      st = e.st;
      if (e.we) mirror[ad] = e.d;
    end
  endtask
  task automatic cmp(rsx_exp_t e);
    num_checks++;
    if (accum !== e.acc || status !== e.st || wb.wr_en !== e.we || wb.data !== e.d
        || (e.we && wb.addr !== e.ad)) begin
      fails++;
      $display("MISMATCH t=%0t op %0d result differs", $time, e.op);
    end
  endtask
  // a done with nothing expected means a refused op was executed
  always @(posedge clock) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH t=%0t unexpected done", $time);
      end else begin
        got = exp_q.pop_front();
        case (got.op)
          OP_ROTATE_RIGHT_THRU_CARRY: cmp(got);
          OP_ROTATE_LEFT_THRU_CARRY: cmp(got);
          OP_SUB_ACCUM_FROM_REG: cmp(got);
          OP_NIBBLE_EXCHANGE: cmp(got);
          OP_XOR_IMMEDIATE_TO_ACCUM: cmp(got);
          default: cmp(got);
        endcase
      end
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // about 1,230 cycles of tests; generous margin before giving up
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    issue = 1'b0;
    req = '0;
    acc = ACCUM_RST;
    st = STATUS_RST;
    for (int i = 0; i < 2**ADDR_W; i++) mirror[i] = DATA_W'(i * 37 + 1);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    cmp('0);
    op_do(OP_XOR_IMMEDIATE_TO_ACCUM, 1'b1, 7'h00, acc ^ mirror[0]);
    op_do(OP_SUB_ACCUM_FROM_REG, 1'b1, 7'h00, 8'h00);
    op_do(OP_SUB_ACCUM_FROM_REG, 1'b0, 7'h00, 8'h00);
    $display("directed subtract test done");
    // random mix, refused codes included, addresses at both ends of the file
    for (int n = 0; n < 600; n++) begin
      lfsr = lfsr_next(lfsr);
      op_do(rsx_op_t'(lfsr[2:0]), lfsr[3], {lfsr[4] ? 5'h1f : 5'h00, lfsr[6:5]},
        lfsr[7] ? acc : lfsr[15:8]);
    end
    repeat (3) @(posedge clock);
    if (exp_q.size() != 0) fails++;
    $display("random instruction test done");
    tally_and_finish();
  end
endmodule
